// ==== rtl/mrfcr_pkg.sv ====
// Shared constants for the maintenance request fill and configuration route block
package mrfcr_pkg;
   // ----------------------------------------------------------------
   // Local register addresses on the user maintenance port
   // ----------------------------------------------------------------
   localparam logic [23:0] ADDR_REQ_INFO = 24'h010100; // Request header info
   localparam logic [23:0] ADDR_CSBA = 24'h00005C; // Config-space base mask
   localparam logic [23:0] ADDR_BASE_DEVID = 24'h000060; // Base device ID
   // ----------------------------------------------------------------
   // Request header info fields and reset values
   // ----------------------------------------------------------------
   localparam int TID_LSB = 24; // Transaction ID [31:24]
   localparam int TID_W = 8;
   localparam int PRIO_LSB = 17; // Priority [18:17]
   localparam int PRIO_W = 2;
   localparam int CRF_BIT = 16; // CRF [16]
   localparam int DEST_LSB = 0; // Destination ID [15:0]
   localparam int DEST_W = 16;
   localparam logic [7:0] TID_RST = 8'h00;
   localparam logic [1:0] PRIO_RST = 2'h1;
   localparam logic CRF_RST = 1'b0;
   localparam logic [15:0] DEST_RST = 16'h0000;
   // ----------------------------------------------------------------
   // Configuration-space match field
   // ----------------------------------------------------------------
   localparam int CSBA_W = 10; // Mask width
   localparam int CSBA_ADDR_LSB = 24; // Compared address [33:24]
   localparam int IO_ADDR_W = 34;
   // ----------------------------------------------------------------
   // Transaction type codes
   // ----------------------------------------------------------------
   localparam logic [3:0] FTYPE_MAINT = 4'h8;
   localparam logic [3:0] TTYPE_PORT_WRITE = 4'h4;
   // ----------------------------------------------------------------
   // Outgoing request word: tid, prio, crf, dest, write, addr, data
   // ----------------------------------------------------------------
   localparam int REQ_ADDR_W = 24;
   localparam int REQ_WORD_W = 84;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_CNT_W = 5;
endpackage

// ==== rtl/mrfcr_fifo.sv ====
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/100ps
module mrfcr_fifo #(
   parameter int WIDTH = 84,
   parameter int DEPTH = 16,
   parameter int CNT_W = 5
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   output logic [CNT_W-1:0] count_o
);
   // ----------------------------------------------------------------
   // Storage and pointers
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] mem [DEPTH]; // Word storage
   logic [CNT_W-2:0] wr_ptr, next_wr_ptr; // Write index
   logic [CNT_W-2:0] rd_ptr, next_rd_ptr; // Read index
   logic [CNT_W-1:0] count, next_count; // Words held
   logic push, pop; // Accepted transfers

   // Honest flags from the count
   assign in_ready_o = (count != CNT_W'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o = mem[rd_ptr];
   assign count_o = count;
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // Next pointer and count
   always_comb begin
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count = count;
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   // Pointer registers
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   // Storage write, no reset needed
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   chk_fifo_no_overflow: assert property (@(posedge clk_i) disable iff (!resetn_i)
      count <= CNT_W'(DEPTH)) else $error("fifo count above depth");
endmodule

// ==== rtl/mrfcr_route.sv ====
// Incoming I/O transaction steering by configuration-space base match
`timescale 1ns/100ps
module mrfcr_route
   import mrfcr_pkg::*;
#(
   parameter logic [15:0] SUPPORTED_FTYPES = 16'h0064,
   parameter bit CSBA_ENABLE = 1'b1
) (
   input wire logic valid_i,
   input wire logic simple_i,
   input wire logic [3:0] ftype_i,
   input wire logic [3:0] ttype_i,
   input wire logic [IO_ADDR_W-1:0] addr_i,
   input wire logic [CSBA_W-1:0] mask_i,
   output logic to_maint_o,
   output logic to_user_o,
   output logic drop_o
);
   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   // Packet type built into the simplified header logic
   function automatic logic type_supported(input logic [3:0] ft);
      type_supported = SUPPORTED_FTYPES[ft];
   endfunction

   // Port-write packets are never handled
   function automatic logic is_port_write(input logic [3:0] ft, input logic [3:0] tt);
      is_port_write = (ft == FTYPE_MAINT) && (tt == TTYPE_PORT_WRITE);
   endfunction

   logic hit; // Upper address equals mask

   // Compare address [33:24], extended bits included
   assign hit = (addr_i[IO_ADDR_W-1:CSBA_ADDR_LSB] == mask_i);

   // Steering decision
   always_comb begin
      to_maint_o = 1'b0;
      to_user_o = 1'b0;
      drop_o = 1'b0;
      if (valid_i) begin
         if (is_port_write(ftype_i, ttype_i)) begin
            drop_o = 1'b1;
         end else if (CSBA_ENABLE && hit && simple_i && type_supported(ftype_i)) begin
            to_maint_o = 1'b1;
         end else begin
            to_user_o = 1'b1;
         end
      end
   end
endmodule

// ==== rtl/mrfcr_top.sv ====
// Maintenance request header fill and configuration-space routing
// Overview of operation
// - Next request carries stored TID, reset zero
// - TID advances by one per remote request
// - Priority field, reset 01, on requests
// - CRF bit copied into every request
// - CRF read-only when CRF unsupported
// - Destination ID field used in requests
// - Info register lives in logical layer
// - Matching I/O goes to maintenance port
// - Ten-bit mask versus address 33:24
// - Base mask reset from generation value
// - Match only supported simplified-header types
// - Base device ID reset from generation
// - Device ID width matches link partner
// - Port-write neither sent nor accepted
// - Header logic only for enabled types
// - Remote maintenance sourcing always enabled
// - Info register only via maintenance path
`timescale 1ns/100ps
module mrfcr_top
   import mrfcr_pkg::*;
#(
   parameter logic [CSBA_W-1:0] CSBA_MASK_RST = 10'h000,
   parameter logic [31:0] COMPONENT_DEVID = 32'h0000_00FF,
   parameter bit CRF_SUPPORT = 1'b1,
   parameter bit LARGE_DEVID = 1'b0,
   parameter bit CSBA_ENABLE = 1'b1,
   parameter logic [15:0] SUPPORTED_FTYPES = 16'h0064
) (
   input wire logic SYS_CLK_I,
   input wire logic RESETN_I,
   input wire logic MREQ_VALID_I,
   output logic MREQ_READY_O,
   input wire logic MREQ_REMOTE_I,
   input wire logic MREQ_WRITE_I,
   input wire logic MREQ_PWRITE_I,
   input wire logic [mrfcr_pkg::REQ_ADDR_W-1:0] MREQ_ADDR_I,
   input wire logic [31:0] MREQ_WDATA_I,
   output logic MRSP_VALID_O,
   output logic MRSP_ERR_O,
   output logic [31:0] MRSP_DATA_O,
   output logic TX_VALID_O,
   input wire logic TX_READY_I,
   output logic [mrfcr_pkg::REQ_WORD_W-1:0] TX_DATA_O,
   input wire logic IO_VALID_I,
   input wire logic IO_SIMPLE_I,
   input wire logic [3:0] IO_FTYPE_I,
   input wire logic [3:0] IO_TTYPE_I,
   input wire logic [mrfcr_pkg::IO_ADDR_W-1:0] IO_ADDR_I,
   output logic IO_TO_MAINT_O,
   output logic IO_TO_USER_O,
   output logic IO_DROP_O
);
   import mrfcr_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [TID_W-1:0] tid, next_tid; // Request transaction ID
   logic [PRIO_W-1:0] prio, next_prio; // Request priority
   logic crf, next_crf; // Request CRF
   logic [DEST_W-1:0] dest, next_dest; // Request destination ID
   logic [CSBA_W-1:0] csba, next_csba; // Config-space base mask
   logic [31:0] base_devid, next_base_devid; // Base device ID
   logic ready, next_ready; // Request port ready
   logic rsp_valid, next_rsp_valid; // Response strobe
   logic rsp_err, next_rsp_err; // Response error
   logic [31:0] rsp_data, next_rsp_data; // Response data
   logic tx_valid, next_tx_valid; // Output stage valid
   logic [REQ_WORD_W-1:0] tx_data, next_tx_data; // Output stage word
   logic to_maint, to_user, drop; // Route decision
   logic r_maint, r_user, r_drop; // Registered route pulses
   logic accept; // Request taken this cycle
   logic push; // Remote request into FIFO
   logic fifo_in_ready; // FIFO has room
   logic fifo_out_valid; // FIFO holds a word
   logic fifo_pop; // Move word to output stage
   logic [REQ_WORD_W-1:0] fifo_out_data; // FIFO head
   logic [FIFO_CNT_W-1:0] fifo_count; // FIFO fill level
   logic [REQ_WORD_W-1:0] req_word; // Header-filled request
   logic [DEST_W-1:0] hdr_dest; // Destination sized to ID width
   logic [31:0] info_read; // Info register read view

   // ----------------------------------------------------------------
   // Request acceptance
   // ----------------------------------------------------------------
   assign accept = MREQ_VALID_I && ready;
   // Remote sourcing cannot be switched off; port-write is refused
   assign push = accept && MREQ_REMOTE_I && !MREQ_PWRITE_I;

   // Small-system IDs keep the upper destination byte clear
   assign hdr_dest = LARGE_DEVID ? dest : {8'h00, dest[7:0]};

   // Header taken from the register as it stands at issue
   assign req_word = {tid, prio, crf, hdr_dest, MREQ_WRITE_I,
                      MREQ_ADDR_I, MREQ_WDATA_I};

   // Read view with reserved bits as zero
   assign info_read = {tid, 5'h00, prio, crf, dest};

   // ----------------------------------------------------------------
   // Request information register and local registers
   // ----------------------------------------------------------------
   // Next values for the locally held registers
   always_comb begin
      next_tid = tid;
      next_prio = prio;
      next_crf = crf;
      next_dest = dest;
      next_csba = csba;
      next_base_devid = base_devid;
      if (push) begin
         // Advance in the same cycle the request is pushed into the FIFO
         next_tid = tid + 1'b1;
      end else if (accept && !MREQ_REMOTE_I && MREQ_WRITE_I) begin
         // Local writes reach only through the maintenance port
         case (MREQ_ADDR_I)
            ADDR_REQ_INFO: begin
               next_tid = MREQ_WDATA_I[TID_LSB +: TID_W];
               next_prio = MREQ_WDATA_I[PRIO_LSB +: PRIO_W];
               if (CRF_SUPPORT) begin
                  next_crf = MREQ_WDATA_I[CRF_BIT];
               end
               next_dest = MREQ_WDATA_I[DEST_LSB +: DEST_W];
            end
            ADDR_CSBA: begin
               next_csba = MREQ_WDATA_I[CSBA_W-1:0];
            end
            ADDR_BASE_DEVID: begin
               next_base_devid = MREQ_WDATA_I;
            end
            default: begin
               next_tid = tid;
            end
         endcase
      end
   end

   // Register update
   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         tid <= TID_RST;
         prio <= PRIO_RST;
         crf <= CRF_RST;
         dest <= DEST_RST;
         csba <= CSBA_MASK_RST;
         base_devid <= COMPONENT_DEVID;
      end else begin
         tid <= next_tid;
         prio <= next_prio;
         crf <= next_crf;
         dest <= next_dest;
         csba <= next_csba;
         base_devid <= next_base_devid;
      end
   end

   // ----------------------------------------------------------------
   // Handshake and response
   // ----------------------------------------------------------------
   // One request per two cycles; stall while FIFO nearly full
   always_comb begin
      next_ready = !accept && (fifo_count < FIFO_CNT_W'(FIFO_DEPTH - 1));
      next_rsp_valid = accept;
      next_rsp_err = 1'b0;
      next_rsp_data = 32'h0000_0000;
      if (accept) begin
         if (MREQ_PWRITE_I) begin
            next_rsp_err = 1'b1;
         end else if (!MREQ_REMOTE_I && !MREQ_WRITE_I) begin
            case (MREQ_ADDR_I)
               ADDR_REQ_INFO: next_rsp_data = info_read;
               ADDR_CSBA: next_rsp_data = {22'h000000, csba};
               ADDR_BASE_DEVID: next_rsp_data = base_devid;
               default: next_rsp_err = 1'b1;
            endcase
         end else if (!MREQ_REMOTE_I) begin
            // Unmapped local write answers with an error
            case (MREQ_ADDR_I)
               ADDR_REQ_INFO, ADDR_CSBA, ADDR_BASE_DEVID: next_rsp_err = 1'b0;
               default: next_rsp_err = 1'b1;
            endcase
         end
      end
   end

   // Handshake registers
   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_err <= 1'b0;
         rsp_data <= 32'h0000_0000;
      end else begin
         ready <= next_ready;
         rsp_valid <= next_rsp_valid;
         rsp_err <= next_rsp_err;
         rsp_data <= next_rsp_data;
      end
   end

   // ----------------------------------------------------------------
   // Outbound buffer and output stage
   // ----------------------------------------------------------------
   // Request buffer toward the link side
   mrfcr_fifo #(
      .WIDTH(REQ_WORD_W),
      .DEPTH(FIFO_DEPTH),
      .CNT_W(FIFO_CNT_W)
   ) u_fifo (
      .clk_i(SYS_CLK_I),
      .resetn_i(RESETN_I),
      .in_valid_i(push),
      .in_ready_o(fifo_in_ready),
      .in_data_i(req_word),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_pop),
      .out_data_o(fifo_out_data),
      .count_o(fifo_count)
   );

   assign fifo_pop = fifo_out_valid && (!tx_valid || TX_READY_I);

   // Output stage load and release
   always_comb begin
      next_tx_valid = tx_valid;
      next_tx_data = tx_data;
      if (fifo_pop) begin
         next_tx_valid = 1'b1;
         next_tx_data = fifo_out_data;
      end else if (TX_READY_I) begin
         next_tx_valid = 1'b0;
      end
   end

   // Output stage registers
   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         tx_valid <= 1'b0;
         tx_data <= '0;
      end else begin
         tx_valid <= next_tx_valid;
         tx_data <= next_tx_data;
      end
   end

   // ----------------------------------------------------------------
   // Incoming I/O routing
   // ----------------------------------------------------------------
   // Decoder built only for enabled packet types
   mrfcr_route #(
      .SUPPORTED_FTYPES(SUPPORTED_FTYPES),
      .CSBA_ENABLE(CSBA_ENABLE)
   ) u_route (
      .valid_i(IO_VALID_I),
      .simple_i(IO_SIMPLE_I),
      .ftype_i(IO_FTYPE_I),
      .ttype_i(IO_TTYPE_I),
      .addr_i(IO_ADDR_I),
      .mask_i(csba),
      .to_maint_o(to_maint),
      .to_user_o(to_user),
      .drop_o(drop)
   );

   // Route pulses registered
   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         r_maint <= 1'b0;
         r_user <= 1'b0;
         r_drop <= 1'b0;
      end else begin
         r_maint <= to_maint;
         r_user <= to_user;
         r_drop <= drop;
      end
   end

   // ----------------------------------------------------------------
   // Output wiring
   // ----------------------------------------------------------------
   assign MREQ_READY_O = ready;
   assign MRSP_VALID_O = rsp_valid;
   assign MRSP_ERR_O = rsp_err;
   assign MRSP_DATA_O = rsp_data;
   assign TX_VALID_O = tx_valid;
   assign TX_DATA_O = tx_data;
   assign IO_TO_MAINT_O = r_maint;
   assign IO_TO_USER_O = r_user;
   assign IO_DROP_O = r_drop;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RESETN_I);

   sequence s_remote_issue;
      MREQ_VALID_I && ready && MREQ_REMOTE_I && !MREQ_PWRITE_I;
   endsequence

   chk_tid_advance: assert property (s_remote_issue |=> tid == $past(tid) + 8'h01)
      else $error("tid did not advance after request");
   chk_header_tid: assert property (push |-> req_word[REQ_WORD_W-1 -: TID_W] == tid)
      else $error("header tid mismatch");
   chk_header_prio: assert property (push |-> req_word[75:74] == prio)
      else $error("header priority mismatch");
   chk_header_crf: assert property (push |-> req_word[73] == crf)
      else $error("header crf mismatch");
   chk_crf_readonly: assert property (!CRF_SUPPORT |-> crf == CRF_RST)
      else $error("crf changed while unsupported");
   chk_header_dest: assert property (push && LARGE_DEVID |-> req_word[72:57] == dest)
      else $error("header destination mismatch");
   chk_small_dest: assert property (push && !LARGE_DEVID |-> req_word[72:65] == 8'h00)
      else $error("small-system header upper destination byte not clear");
   chk_fifo_room: assert property (push |-> fifo_in_ready)
      else $error("request pushed into a full buffer");
   chk_match_route: assert property (IO_VALID_I && IO_SIMPLE_I && CSBA_ENABLE
      && SUPPORTED_FTYPES[IO_FTYPE_I] && IO_ADDR_I[33:24] == csba
      && !(IO_FTYPE_I == FTYPE_MAINT && IO_TTYPE_I == TTYPE_PORT_WRITE)
      |=> IO_TO_MAINT_O && !IO_TO_USER_O)
      else $error("matching transaction not sent to maintenance");
   chk_pwrite_drop: assert property (IO_VALID_I && IO_FTYPE_I == FTYPE_MAINT
      && IO_TTYPE_I == TTYPE_PORT_WRITE |=> IO_DROP_O && !IO_TO_MAINT_O)
      else $error("port-write not dropped");
   chk_pwrite_refuse: assert property (accept && MREQ_PWRITE_I
      |-> !push ##1 MRSP_VALID_O && MRSP_ERR_O)
      else $error("port-write request not refused");
   chk_sample_hold: assert property (s_remote_issue ##1 !push [*2]
      |-> tid == $past(tid, 2) + 8'h01)
      else $error("tid moved without a request");
endmodule

// ==== test/mrfcr_sink.sv ====
// Link-side model that takes outgoing request words, promptly or slowly
`timescale 1ns/100ps
module mrfcr_sink (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic tx_valid_i,
   input wire logic hold_i,
   input wire logic slow_i,
   output logic tx_ready_o,
   output logic take_o
);
   // -----------------------------------------
   // Ready generation
   // -----------------------------------------
   // Hold stalls fully, slow takes every other cycle
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tx_ready_o <= 1'b0;
      end else begin
         tx_ready_o <= !hold_i && !(slow_i && tx_ready_o);
      end
   end
   // Word taken at this edge
   assign take_o = tx_valid_i & tx_ready_o;
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the request fill and routing block
`timescale 1ns/100ps
module testbench;
   import mrfcr_pkg::*;
   // -----------------------------------------
   // Signals and bench state
   // -----------------------------------------
   logic clk = 1'b0, rstn = 1'b0, mv = 1'b0, mr, mrem = 1'b0, mw = 1'b0, mpw = 1'b0;
   logic [23:0] ma = 24'h000000;
   logic [31:0] mwd = 32'h00000000, rd, rdat, rd2, rdat2;
   logic rv, re, txv, txv2, txr, take, err, ok, hold = 1'b1, slow = 1'b0;
   logic [83:0] txd, txd2;
   logic iov = 1'b0, ios = 1'b0, tom, tou, tod, tom2, tou2, tod2;
   logic [3:0] ift = 4'h0, itt = 4'h0;
   logic [33:0] ia = 34'h000000000;
   logic [7:0] tid = 8'h00;
   logic [1:0] prio_m = 2'h1;
   logic crf_m = 1'b0;
   logic [15:0] dest_m = 16'h0000;
   logic [83:0] expq[$], expq2[$];
   logic [45:0] tbl [0:6];
   int mismatches = 0, n_checks = 0, cyc = 0, acc, k;
   // Clock, 10 ns period
   always #5 clk = ~clk;
   // -----------------------------------------
   // Design and link-side model
   // -----------------------------------------
   mrfcr_top #(.CSBA_MASK_RST(10'h2A5), .COMPONENT_DEVID(32'h0000_0042)) dut_u (
      .SYS_CLK_I(clk), .RESETN_I(rstn), .MREQ_VALID_I(mv), .MREQ_READY_O(mr),
      .MREQ_REMOTE_I(mrem), .MREQ_WRITE_I(mw), .MREQ_PWRITE_I(mpw), .MREQ_ADDR_I(ma),
      .MREQ_WDATA_I(mwd), .MRSP_VALID_O(rv), .MRSP_ERR_O(re), .MRSP_DATA_O(rd),
      .TX_VALID_O(txv), .TX_READY_I(txr), .TX_DATA_O(txd), .IO_VALID_I(iov),
      .IO_SIMPLE_I(ios), .IO_FTYPE_I(ift), .IO_TTYPE_I(itt), .IO_ADDR_I(ia),
      .IO_TO_MAINT_O(tom), .IO_TO_USER_O(tou), .IO_DROP_O(tod));
   // Second build: CRF unsupported, large IDs, base matching off
   mrfcr_top #(.CSBA_MASK_RST(10'h2A5), .COMPONENT_DEVID(32'h0000_0042), .CRF_SUPPORT(1'b0),
      .LARGE_DEVID(1'b1), .CSBA_ENABLE(1'b0)) dut_alt_u (
      .SYS_CLK_I(clk), .RESETN_I(rstn), .MREQ_VALID_I(mv), .MREQ_READY_O(),
      .MREQ_REMOTE_I(mrem), .MREQ_WRITE_I(mw), .MREQ_PWRITE_I(mpw), .MREQ_ADDR_I(ma),
      .MREQ_WDATA_I(mwd), .MRSP_VALID_O(), .MRSP_ERR_O(), .MRSP_DATA_O(rd2),
      .TX_VALID_O(txv2), .TX_READY_I(txr), .TX_DATA_O(txd2), .IO_VALID_I(iov),
      .IO_SIMPLE_I(ios), .IO_FTYPE_I(ift), .IO_TTYPE_I(itt), .IO_ADDR_I(ia),
      .IO_TO_MAINT_O(tom2), .IO_TO_USER_O(tou2), .IO_DROP_O(tod2));
   mrfcr_sink sink_u (.clk_i(clk), .resetn_i(rstn), .tx_valid_i(txv), .hold_i(hold),
      .slow_i(slow), .tx_ready_o(txr), .take_o(take));
   // -----------------------------------------
   // Tasks
   // -----------------------------------------
   // Compare and count
   task automatic chk(input logic [83:0] got, input logic [83:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One request on the maintenance port, answer sampled one cycle later
   task automatic mreq(input logic r, w, pw, input logic [23:0] a, input logic [31:0] d);
      ok = 1'b0;
      @(posedge clk);
      mv <= 1'b1; mrem <= r; mw <= w; mpw <= pw; ma <= a; mwd <= d;
      for (int i = 0; i < 8 && !ok; i++) begin
         @(negedge clk);
         ok = (mr === 1'b1);
      end
      @(posedge clk);
      mv <= 1'b0;
      if (ok) begin
         @(negedge clk);
         ok = (rv === 1'b1);
         err = re;
         rdat = rd;
         rdat2 = rd2;
      end
   endtask
   // Rewrite the info register, reserved bits written as ones
   task automatic setinfo(input logic [7:0] t, input logic [1:0] p, input logic c,
                          input logic [15:0] d);
      mreq(1'b0, 1'b1, 1'b0, ADDR_REQ_INFO, {t, 5'h1F, p, c, d});
      chk({ok, err}, 2'h2);
      tid = t; prio_m = p; crf_m = c; dest_m = d;
   endtask
   // Local read with expected data
   task automatic rdchk(input logic [23:0] a, input logic [31:0] e);
      mreq(1'b0, 1'b0, 1'b0, a, 32'h0);
      chk({ok, err, rdat}, {2'h2, e});
   endtask
   // Remote write; expected header queued when accepted
   task automatic remote(input logic [23:0] a);
      mreq(1'b1, 1'b1, 1'b0, a, {8'hA5, a});
      if (ok) begin
         expq.push_back({tid, prio_m, crf_m, 8'h00, dest_m[7:0], 1'b1, a, 8'hA5, a});
         expq2.push_back({tid, prio_m, 1'b0, dest_m, 1'b1, a, 8'hA5, a});
         tid = tid + 8'h01;
      end
   endtask
   // Back-to-back incoming transactions, verdict one cycle later
   task automatic iorun(input int lo, input int hi);
      for (int i = lo; i <= hi + 1; i++) begin
         @(posedge clk);
         iov <= (i <= hi);
         if (i <= hi) {ios, ift, itt, ia} <= tbl[i][45:3];
         if (i > lo) begin
            @(negedge clk);
            chk({tom, tou, tod}, tbl[i-1][2:0]);
            chk({tom2, tou2, tod2}, tbl[i-1][2] ? 3'h2 : tbl[i-1][2:0]);
         end
      end
   endtask
   // Counts, verdict and end of run
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // -----------------------------------------
   // Watchers
   // -----------------------------------------
   // Each word leaving for the link matches the oldest expected header
   always @(posedge clk) begin
      if (take === 1'b1) begin
         if (expq.size() == 0 || expq2.size() == 0) chk(84'h1, 84'h0);
         else begin
            chk(txd, expq.pop_front());
            chk(txd2, expq2.pop_front());
         end
      end
   end
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         results();
      end
   end
   // -----------------------------------------
   // Main sequence
   // -----------------------------------------
   initial begin
      tbl[0] = {1'b1, 4'h2, 4'h0, 34'h2A5000000, 3'h4};
      tbl[1] = {1'b1, 4'h5, 4'h0, 34'h2A4FFFFFF, 3'h2};
      tbl[2] = {1'b0, 4'h6, 4'h0, 34'h2A5000000, 3'h2};
      tbl[3] = {1'b1, 4'h1, 4'h0, 34'h2A5000000, 3'h2};
      tbl[4] = {1'b1, 4'h8, 4'h4, 34'h2A5000000, 3'h1};
      tbl[5] = {1'b1, 4'h6, 4'h0, 34'h3FF000010, 3'h4};
      tbl[6] = {1'b1, 4'h2, 4'h0, 34'h2A5000000, 3'h2};
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      rdchk(ADDR_REQ_INFO, 32'h0002_0000);
      rdchk(ADDR_CSBA, 32'h0000_02A5);
      rdchk(ADDR_BASE_DEVID, 32'h0000_0042);
      $display("test reset_values done");
      setinfo(8'hFE, 2'h3, 1'b1, 16'h12CD);
      rdchk(ADDR_REQ_INFO, 32'hFE07_12CD);
      chk(rdat2, 32'hFE06_12CD);
      remote(24'h000010);
      remote(24'h000014);
      setinfo(8'h10, 2'h0, 1'b0, 16'h0077);
      remote(24'h000018);
      rdchk(ADDR_REQ_INFO, 32'h1100_0077);
      $display("test header_fill done");
      mreq(1'b1, 1'b1, 1'b1, 24'h000020, 32'h1);
      chk({ok, err}, 2'h3);
      mreq(1'b0, 1'b0, 1'b0, 24'h000100, 32'h0);
      chk({ok, err}, 2'h3);
      $display("test refusals done");
      acc = 3;
      ok = 1'b1;
      while (ok && acc < 20) begin
         remote(24'(acc * 4));
         if (ok) acc++;
      end
      chk(84'(acc), 84'd16);
      hold <= 1'b0;
      slow <= 1'b1;
      for (k = 0; k < 400 && expq.size() > 0; k++) @(negedge clk);
      repeat (2) @(negedge clk);
      chk({txv, txv2, 32'(expq.size()), 32'(expq2.size())}, 66'h0);
      $display("test buffer_fill done");
      iorun(0, 4);
      mreq(1'b0, 1'b1, 1'b0, ADDR_CSBA, 32'h0000_03FF);
      chk({ok, err}, 2'h2);
      iorun(5, 6);
      $display("test io_route done");
      results();
   end
endmodule
